// >>> rtl/eeh_pkg.sv
// Shared constants and types for the two-wire memory host controller.
// Assumes a 40 MHz system clock and a host-side plain register port.
package eeh_pkg;

  // System and link timing
  localparam int CLK_HZ       = 40_000_000;
  localparam int SCL_HZ       = 100_000;
  localparam int QTR_CYC      = (CLK_HZ + 4 * SCL_HZ - 1) / (4 * SCL_HZ);
  localparam int PROG_TIME_MS = 20;
  localparam int PROG_CYC     = PROG_TIME_MS * (CLK_HZ / 1000);

  // Widths
  localparam int QCNT_W    = 16;
  localparam int TIM_W     = 24;
  localparam int ADDR_W    = 15;
  localparam int BUF_DEPTH = 64;
  localparam int BUF_AW    = 6;
  localparam int RADDR_W   = 9;

  // Recovery clock limit and byte bit count
  localparam logic [3:0] REC_LAST = 4'h8;
  localparam logic [3:0] ACK_BIT  = 4'h8;

  // Register offsets
  localparam logic [RADDR_W-1:0] OFS_CMD  = 9'h000;
  localparam logic [RADDR_W-1:0] OFS_CFG  = 9'h004;
  localparam logic [RADDR_W-1:0] OFS_ADDR = 9'h008;
  localparam logic [RADDR_W-1:0] OFS_LEN  = 9'h00c;
  localparam logic [RADDR_W-1:0] OFS_STAT = 9'h010;
  localparam logic [RADDR_W-1:0] OFS_BUF  = 9'h100;

  // Command codes
  localparam logic [2:0] OP_WRITE = 3'h1;
  localparam logic [2:0] OP_CUR   = 3'h2;
  localparam logic [2:0] OP_RAND  = 3'h3;
  localparam logic [2:0] OP_RECOV = 3'h4;

  // Field positions
  localparam int CFG_STRAP_LO = 0;
  localparam int CFG_STRAP_HI = 1;
  localparam int CFG_WP       = 2;
  localparam int ST_BUSY      = 0;
  localparam int ST_DONE      = 1;
  localparam int ST_NACK      = 2;
  localparam int ST_TMO       = 3;

  typedef enum logic [2:0] {
    EEH_IDLE  = 3'h0,
    EEH_START = 3'h1,
    EEH_BIT   = 3'h3,
    EEH_STOP  = 3'h2,
    EEH_RECOV = 3'h6
  } eeh_state_t;

  typedef enum logic [2:0] {
    STG_DEVW = 3'h0,
    STG_AHI  = 3'h1,
    STG_ALO  = 3'h3,
    STG_WDAT = 3'h2,
    STG_DEVR = 3'h6,
    STG_RDAT = 3'h7
  } eeh_stage_t;

endpackage : eeh_pkg

// >>> rtl/eeh_buf_mem.sv
// Byte buffer for page write data and read results.
// Assumes one writer and one reader per cycle on the same clock.
`timescale 1ns/10ps
module eeh_buf_mem #(
  parameter int DW    = 8,
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  input  wire logic          clock_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [DW-1:0] rdata_o
);

  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge clock_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end

endmodule : eeh_buf_mem

// >>> rtl/eeh_host.sv
// Host engine driving a two-wire serial memory: byte/page write with
// acknowledge polling, current, random and sequential reads, bus recovery.
// Assumes an external pull-up on the data line and a device on the far end.
`timescale 1ns/10ps
module eeh_host #(
  parameter int             QTR         = eeh_pkg::QTR_CYC,
  parameter int             PROG_CYCLES = eeh_pkg::PROG_CYC,
  parameter logic [4:0]     TYPE_CODE   = 5'h0b  // Arbitrary value
) (
  input  wire logic                        clock_i,
  input  wire logic                        srst_i,
  input  wire logic [eeh_pkg::RADDR_W-1:0] reg_addr_i,
  input  wire logic [31:0]                 reg_wdata_i,
  input  wire logic                        reg_we_i,
  input  wire logic                        reg_re_i,
  output logic      [31:0]                 reg_rdata_o,
  output logic                             scl_o,
  input  wire logic                        sda_i,
  output logic                             sda_o,
  output logic                             sda_oe_o,
  output logic                             wp_o
);

  typedef struct packed {
    eeh_pkg::eeh_state_t        fsm;
    eeh_pkg::eeh_stage_t        stg;
    logic [1:0]                 sda_sy;
    logic [eeh_pkg::QCNT_W-1:0] qcnt;
    logic [1:0]                 qph;
    logic [3:0]                 bitn;
    logic [7:0]                 sh;
    logic [eeh_pkg::BUF_AW-1:0] idx;
    logic [2:0]                 op;
    logic [3:0]                 rec;
    logic [eeh_pkg::TIM_W-1:0]  ptim;
    logic                       poll;
    logic                       prog;
    logic                       nackb;
    logic                       scl;
    logic                       oe;
    logic                       busy;
    logic                       done;
    logic                       nack;
    logic                       tmo;
    logic [1:0]                 strap;
    logic                       wp;
    logic [eeh_pkg::ADDR_W-1:0] addr;
    logic [eeh_pkg::BUF_AW-1:0] len;
    logic [31:0]                rdat;
    logic                       rsel;
  } eeh_st_t;

  eeh_st_t                    s_q;
  eeh_st_t                    s_d;
  logic                       tick;
  logic                       sda_s;
  logic                       tx;
  logic                       buf_hit;
  logic                       eng_we;
  logic                       last;
  logic [7:0]                 txb;
  logic [7:0]                 mem_q;
  logic                       mem_we;
  logic [eeh_pkg::BUF_AW-1:0] mem_wa;
  logic [eeh_pkg::BUF_AW-1:0] mem_ra;
  logic [7:0]                 mem_wd;

  assign tick    = (s_q.fsm != eeh_pkg::EEH_IDLE) && (s_q.qcnt == eeh_pkg::QCNT_W'(QTR - 1));
  assign sda_s   = s_q.sda_sy[1];
  assign tx      = (s_q.stg != eeh_pkg::STG_RDAT);
  assign last    = (s_q.idx == s_q.len);
  assign buf_hit = (reg_addr_i[eeh_pkg::RADDR_W-1:8] == eeh_pkg::OFS_BUF[eeh_pkg::RADDR_W-1:8]);
  assign txb     = (s_q.stg == eeh_pkg::STG_WDAT && s_q.bitn == 4'h0) ? mem_q : s_q.sh;
  assign eng_we  = tick && s_q.fsm == eeh_pkg::EEH_BIT && s_q.stg == eeh_pkg::STG_RDAT
                   && s_q.bitn == eeh_pkg::ACK_BIT && s_q.qph == 2'h0;

  // Engine owns the buffer while busy
  assign mem_we = eng_we || (reg_we_i && buf_hit && !s_q.busy);
  assign mem_wa = s_q.busy ? s_q.idx : reg_addr_i[eeh_pkg::BUF_AW+1:2];
  assign mem_wd = s_q.busy ? s_q.sh : reg_wdata_i[7:0];
  assign mem_ra = s_q.busy ? s_q.idx : reg_addr_i[eeh_pkg::BUF_AW+1:2];

  eeh_buf_mem #(
    .DW    (8),
    .DEPTH (eeh_pkg::BUF_DEPTH),
    .AW    (eeh_pkg::BUF_AW)
  ) u_buf (
    .clock_i (clock_i),
    .we_i    (mem_we),
    .waddr_i (mem_wa),
    .wdata_i (mem_wd),
    .raddr_i (mem_ra),
    .rdata_o (mem_q)
  );

  always_comb begin
    s_d        = s_q;
    s_d.sda_sy = {s_q.sda_sy[0], sda_i};
    s_d.rsel   = 1'b0;
    s_d.rdat   = 32'h0000_0000;
    // Register reads, answered next cycle
    if (reg_re_i) begin
      s_d.rsel = buf_hit;
      case (reg_addr_i)
        eeh_pkg::OFS_CFG:  s_d.rdat = {29'h0000_0000, s_q.wp, s_q.strap};
        eeh_pkg::OFS_ADDR: s_d.rdat = {17'h0_0000, s_q.addr};
        eeh_pkg::OFS_LEN:  s_d.rdat = {26'h000_0000, s_q.len};
        eeh_pkg::OFS_STAT: s_d.rdat = {28'h000_0000, s_q.tmo, s_q.nack, s_q.done, s_q.busy};
        default:           s_d.rdat = 32'h0000_0000;
      endcase
    end
    // Register writes; clears come first so engine sets win
    if (reg_we_i) begin
      case (reg_addr_i)
        eeh_pkg::OFS_CFG: begin
          s_d.strap = reg_wdata_i[eeh_pkg::CFG_STRAP_HI:eeh_pkg::CFG_STRAP_LO];
          s_d.wp    = reg_wdata_i[eeh_pkg::CFG_WP];
        end
        eeh_pkg::OFS_ADDR: s_d.addr = reg_wdata_i[eeh_pkg::ADDR_W-1:0];
        eeh_pkg::OFS_LEN:  s_d.len  = reg_wdata_i[eeh_pkg::BUF_AW-1:0];
        eeh_pkg::OFS_STAT: begin
          if (reg_wdata_i[eeh_pkg::ST_DONE]) s_d.done = 1'b0;
          if (reg_wdata_i[eeh_pkg::ST_NACK]) s_d.nack = 1'b0;
          if (reg_wdata_i[eeh_pkg::ST_TMO])  s_d.tmo  = 1'b0;
        end
        eeh_pkg::OFS_CMD: begin
          if (!s_q.busy && reg_wdata_i[2:0] >= eeh_pkg::OP_WRITE && reg_wdata_i[2:0] <= eeh_pkg::OP_RECOV) begin
            s_d.op   = reg_wdata_i[2:0];
            s_d.busy = 1'b1;
            s_d.idx  = '0;
            s_d.rec  = 4'h0;
            s_d.qph  = 2'h0;
            s_d.qcnt = '0;
            s_d.fsm  = (reg_wdata_i[2:0] == eeh_pkg::OP_RECOV) ? eeh_pkg::EEH_RECOV : eeh_pkg::EEH_START;
            // current read opens with read address
            s_d.stg  = (reg_wdata_i[2:0] == eeh_pkg::OP_CUR) ? eeh_pkg::STG_DEVR : eeh_pkg::STG_DEVW;
          end
        end
        default: ;
      endcase
    end
    if (s_q.poll && s_q.ptim != eeh_pkg::TIM_W'(PROG_CYCLES)) begin
      s_d.ptim = s_q.ptim + 1'b1;
    end
    if (s_q.fsm != eeh_pkg::EEH_IDLE) begin
      s_d.qcnt = tick ? '0 : s_q.qcnt + 1'b1;
    end
    if (tick) begin
      s_d.qph = s_q.qph + 1'b1;
      case (s_q.fsm)
        eeh_pkg::EEH_START: begin
          // data falls in the clock-high quarter
          case (s_q.qph)
            2'h0: begin s_d.scl = 1'b0; s_d.oe = 1'b0; end
            2'h1: s_d.scl = 1'b1;
            2'h2: s_d.oe  = 1'b1;
            default: begin
              s_d.scl  = 1'b0;
              s_d.bitn = 4'h0;
              s_d.sh   = {TYPE_CODE, s_q.strap, s_q.stg == eeh_pkg::STG_DEVR};
              s_d.fsm  = (s_q.op == eeh_pkg::OP_RECOV) ? eeh_pkg::EEH_STOP : eeh_pkg::EEH_BIT;
            end
          endcase
        end
        eeh_pkg::EEH_BIT: begin
          case (s_q.qph)
            2'h0: begin
              s_d.scl = 1'b0;
              // data set only while clock low
              if (s_q.bitn != eeh_pkg::ACK_BIT) begin
                s_d.sh = txb;
                s_d.oe = tx & ~txb[7];
              end else begin
                // acknowledge all but the last byte
                s_d.oe = !tx && !last;
              end
            end
            2'h1: s_d.scl = 1'b1;
            2'h2: begin
              if (s_q.bitn != eeh_pkg::ACK_BIT) begin
                if (!tx) s_d.sh = {s_q.sh[6:0], sda_s};
              end else begin
                s_d.nackb = sda_s;
              end
            end
            default: begin
              s_d.scl = 1'b0;
              if (s_q.bitn != eeh_pkg::ACK_BIT) begin
                if (tx) s_d.sh = {s_q.sh[6:0], 1'b0};
                s_d.bitn = s_q.bitn + 1'b1;
              end else begin
                // Host ack held past clock fall, released next quarter
                s_d.bitn = 4'h0;
                if (tx && s_q.nackb) begin
                  // unanswered poll retries after a stop
                  if (!s_q.poll) s_d.nack = 1'b1;
                  s_d.fsm = eeh_pkg::EEH_STOP;
                end else begin
                  case (s_q.stg)
                    eeh_pkg::STG_DEVW: begin
                      if (s_q.poll) begin
                        s_d.poll = 1'b0;
                        s_d.fsm  = eeh_pkg::EEH_STOP;
                      end else begin
                        s_d.stg = eeh_pkg::STG_AHI;
                        s_d.sh  = 8'(s_q.addr >> 8);
                      end
                    end
                    eeh_pkg::STG_AHI: begin
                      s_d.stg = eeh_pkg::STG_ALO;
                      s_d.sh  = s_q.addr[7:0];
                    end
                    eeh_pkg::STG_ALO: begin
                      if (s_q.op == eeh_pkg::OP_WRITE) begin
                        s_d.stg = eeh_pkg::STG_WDAT;
                      end else begin
                        s_d.stg = eeh_pkg::STG_DEVR;
                        s_d.fsm = eeh_pkg::EEH_START;
                      end
                    end
                    eeh_pkg::STG_DEVR: s_d.stg = eeh_pkg::STG_RDAT;
                    default: begin
                      // count bytes, stop after the last
                      if (last) begin
                        s_d.fsm  = eeh_pkg::EEH_STOP;
                        s_d.prog = (s_q.stg == eeh_pkg::STG_WDAT);
                      end else begin
                        s_d.idx = s_q.idx + 1'b1;
                      end
                    end
                  endcase
                end
              end
            end
          endcase
        end
        eeh_pkg::EEH_STOP: begin
          // data rises in the clock-high quarter
          case (s_q.qph)
            2'h0: begin s_d.scl = 1'b0; s_d.oe = 1'b1; end
            2'h1: s_d.scl = 1'b1;
            2'h2: s_d.oe  = 1'b0;
            default: begin
              s_d.stg = eeh_pkg::STG_DEVW;
              if (s_q.prog) begin
                // start polling after the write stop
                s_d.prog = 1'b0;
                s_d.poll = 1'b1;
                s_d.ptim = '0;
                s_d.fsm  = eeh_pkg::EEH_START;
              end else if (s_q.poll && s_q.ptim != eeh_pkg::TIM_W'(PROG_CYCLES)) begin
                s_d.fsm = eeh_pkg::EEH_START;
              end else begin
                s_d.tmo  = s_d.tmo | s_q.poll;
                s_d.poll = 1'b0;
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
                s_d.fsm  = eeh_pkg::EEH_IDLE;
              end
            end
          endcase
        end
        eeh_pkg::EEH_RECOV: begin
          case (s_q.qph)
            2'h0: begin s_d.scl = 1'b0; s_d.oe = 1'b0; end
            2'h1: s_d.scl = 1'b1;
            2'h2: begin
              // released line or ninth clock ends it
              if (sda_s || s_q.rec == eeh_pkg::REC_LAST) begin
                s_d.nack = s_d.nack | ~sda_s;
                s_d.fsm  = eeh_pkg::EEH_START;
                s_d.qph  = 2'h1;
              end
            end
            default: begin
              s_d.scl = 1'b0;
              s_d.rec = s_q.rec + 1'b1;
            end
          endcase
        end
        default: s_d.fsm = eeh_pkg::EEH_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      s_q        <= '0;
      s_q.fsm    <= eeh_pkg::EEH_IDLE;
      s_q.stg    <= eeh_pkg::STG_DEVW;
      s_q.sda_sy <= 2'h3;
      s_q.scl    <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign scl_o       = s_q.scl;
  // open drain: only ever pull low
  assign sda_o       = 1'b0;
  assign sda_oe_o    = s_q.oe;
  assign wp_o        = s_q.wp;
  assign reg_rdata_o = s_q.rsel ? {24'h00_0000, mem_q} : s_q.rdat;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  a_data_clk_low: assert property (
    s_q.fsm == eeh_pkg::EEH_BIT && s_q.scl && $past(s_q.scl) |-> $stable(s_q.oe))
    else $error("data line moved while clock high inside a byte");
  a_start_form: assert property (
    $rose(s_q.oe) && s_q.scl |-> s_q.fsm == eeh_pkg::EEH_START && $past(s_q.scl))
    else $error("data fell with clock high outside a start");
  a_stop_form: assert property (
    $fell(s_q.oe) && s_q.scl |-> s_q.fsm == eeh_pkg::EEH_STOP ##1 s_q.scl [*6])
    else $error("data rose with clock high outside a stop");
  a_type_code: assert property (
    s_q.fsm == eeh_pkg::EEH_BIT && s_q.bitn == 4'h0 && s_q.qph == 2'h0
    && (s_q.stg == eeh_pkg::STG_DEVW || s_q.stg == eeh_pkg::STG_DEVR)
    |-> s_q.sh[7:1] == {TYPE_CODE, s_q.strap})
    else $error("address word lacks type code or strap bits");
  a_dir_bit: assert property (
    $rose(s_q.fsm == eeh_pkg::EEH_BIT) && !s_q.poll
    |-> s_q.sh[0] == (s_q.stg == eeh_pkg::STG_DEVR))
    else $error("direction bit does not match the stage");
  a_last_write_stop: assert property (
    tick && s_q.fsm == eeh_pkg::EEH_BIT && s_q.stg == eeh_pkg::STG_WDAT && last
    && s_q.bitn == eeh_pkg::ACK_BIT && s_q.qph == 2'h3 && !s_q.nackb
    |=> s_q.fsm == eeh_pkg::EEH_STOP && s_q.prog)
    else $error("last page byte not followed by stop");
  a_read_ack: assert property (
    s_q.fsm == eeh_pkg::EEH_BIT && s_q.stg == eeh_pkg::STG_RDAT
    && s_q.bitn == eeh_pkg::ACK_BIT && s_q.scl |-> s_q.oe == !last)
    else $error("read acknowledge does not match remaining count");
  a_recover_cap: assert property (
    s_q.fsm == eeh_pkg::EEH_RECOV |-> s_q.rec <= eeh_pkg::REC_LAST)
    else $error("more than nine recovery clocks");
  a_poll_bound: assert property (
    s_q.poll |-> s_q.ptim <= eeh_pkg::TIM_W'(PROG_CYCLES))
    else $error("polling ran past the programming time");
  a_scl_on_tick: assert property (
    $changed(s_q.scl) && !$past(srst_i) |-> $past(tick))
    else $error("clock moved between quarter ticks");

  c_write_done: cover property (s_q.op == eeh_pkg::OP_WRITE && $rose(s_q.done));
  c_poll_retry: cover property (s_q.poll && s_q.fsm == eeh_pkg::EEH_STOP && s_q.qph == 2'h3 && tick);
  c_seq_read:   cover property (s_q.stg == eeh_pkg::STG_RDAT && s_q.idx == 6'h02);
  c_recover:    cover property (s_q.op == eeh_pkg::OP_RECOV && $fell(s_q.busy));

endmodule : eeh_host

// >>> tb/eeh_mem_model.sv
// Behavioural two-wire serial memory facing the host engine.
// Assumes a resolved data line and a push-pull serial clock from the host.
`timescale 1ns/10ps
module eeh_mem_model #(
  parameter logic [4:0] TYPE_CODE = 5'h0b,  // Arbitrary value
  parameter int         PROG_NS   = 20000
) (
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic [1:0] strap_i,
  input  wire logic       wp_i,
  output logic            pull_o
);
  logic [7:0]  mem [0:32767];
  logic [14:0] ptr = '0;
  logic [7:0]  sh = '0;
  int          bitn = 0;
  int          ph = 0;
  bit          wrote = 0;
  realtime     busy_end = 0;

  initial begin
    pull_o = 1'b0;
    for (int a = 0; a < 32768; a++) mem[a] = a[7:0] ^ {1'b0, a[14:8]};
  end

  task automatic take_byte();
    pull_o = 1'b1;
    case (ph)
      1: if (sh[7:3] == TYPE_CODE && sh[2:1] == strap_i && $realtime >= busy_end) ph = sh[0] ? 5 : 2;
         else begin
           ph = 0;
           pull_o = 1'b0;
         end
      2: begin
        ptr[14:8] = sh[6:0];
        ph = 3;
      end
      3: begin
        ptr[7:0] = sh;
        wrote = 0;
        ph = 4;
      end
      default: begin
        if (!wp_i) mem[ptr] = sh;
        ptr[5:0] = ptr[5:0] + 1'b1;
        wrote = 1;
      end
    endcase
  endtask : take_byte

  always @(negedge sda_i) if (scl_i) begin
    ph = 1;
    // First clock fall belongs to the start itself
    bitn = -1;
    pull_o = 1'b0;
  end

  always @(posedge sda_i) if (scl_i) begin
    if (ph == 4 && wrote && !wp_i) busy_end = $realtime + PROG_NS;
    ph = 0;
    pull_o = 1'b0;
  end

  always @(posedge scl_i) if (ph != 0) begin
    if (bitn < 8) sh = {sh[6:0], sda_i};
    else if (ph == 5 && sda_i) ph = 6;
  end

  always @(negedge scl_i) if (ph != 0 && ph != 6) begin
    if (bitn == 8) begin
      bitn = 0;
      pull_o = (ph == 5) ? ~mem[ptr][7] : 1'b0;
    end else if (bitn == 7) begin
      bitn = 8;
      pull_o = 1'b0;
      if (ph == 5) ptr = ptr + 1'b1;
      else take_byte();
    end else begin
      bitn = bitn + 1;
      if (ph == 5) pull_o = ~mem[ptr][7 - bitn];
    end
  end
endmodule : eeh_mem_model

// >>> tb/tb_eeh_host.sv
// Self-checking bench for the two-wire memory host engine.
// Assumes the behavioural memory model and a pull-up on the data line.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin error_cnt++; \
  $display("mismatch %s exp %h got %h", nm, ex, got); end end
module tb_eeh_host;
  logic        clock_i = 1'b0;
  logic        srst_i = 1'b1;
  logic [8:0]  reg_addr_i = '0;
  logic [31:0] reg_wdata_i = '0;
  logic        reg_we_i = 1'b0;
  logic        reg_re_i = 1'b0;
  logic        stuck = 1'b0;
  logic [31:0] reg_rdata_o, d;
  logic        scl_o, sda_o, sda_oe_o, wp_o, pull;
  logic [1:0]  dev_strap;
  logic [7:0]  shadow [0:32767];
  logic [14:0] exp_ptr = '0, a;
  logic [5:0]  n;
  int          error_cnt = 0, n_compared = 0, cyc = 0;
  wire logic   sda = ~(sda_oe_o | pull | stuck);

  eeh_host #(.QTR(4), .PROG_CYCLES(2000), .TYPE_CODE(5'h0b)) uut (
    .clock_i(clock_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .scl_o(scl_o),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .wp_o(wp_o));
  eeh_mem_model #(.TYPE_CODE(5'h0b), .PROG_NS(20000)) dev (
    .scl_i(scl_o), .sda_i(sda), .strap_i(dev_strap), .wp_i(wp_o), .pull_o(pull));

  always #12.5 clock_i = ~clock_i;

  task automatic print_verdict();
    if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 80000) begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic wr(input logic [8:0] ad, input logic [31:0] v);
    @(posedge clock_i);
    reg_addr_i <= ad;
    reg_wdata_i <= v;
    reg_we_i <= 1'b1;
    @(posedge clock_i);
    reg_we_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [8:0] ad, output logic [31:0] v);
    @(posedge clock_i);
    reg_addr_i <= ad;
    reg_re_i <= 1'b1;
    @(posedge clock_i);
    reg_re_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask : rd

  task automatic run(input logic [2:0] op, input logic [3:0] exp_st);
    int k;
    wr(eeh_pkg::OFS_CMD, {29'h0, op});
    k = 0;
    do begin
      rd(eeh_pkg::OFS_STAT, d);
      k++;
    end while (d[0] !== 1'b0 && k < 8000);
    `CHK("status", {28'h0, exp_st}, d)
    wr(eeh_pkg::OFS_STAT, 32'h0000_000e);
  endtask : run

  task automatic do_write(input logic [14:0] wa, input logic [5:0] len, input logic wpv);
    logic [7:0] b;
    wr(eeh_pkg::OFS_CFG, {29'h0, wpv, dev_strap});
    wr(eeh_pkg::OFS_ADDR, {17'h0, wa});
    wr(eeh_pkg::OFS_LEN, {26'h0, len});
    for (int i = 0; i <= len; i++) begin
      b = 8'($urandom);
      wr(eeh_pkg::OFS_BUF + 9'(4 * i), {24'h0, b});
      if (!wpv) shadow[{wa[14:6], 6'(wa[5:0] + i)}] = b;
    end
    run(eeh_pkg::OP_WRITE, 4'h2);
    `CHK("write protect pin", wpv, wp_o)
    exp_ptr = {wa[14:6], 6'(wa[5:0] + len + 1)};
  endtask : do_write

  task automatic do_read(input logic [2:0] op, input logic [14:0] ra, input logic [5:0] len);
    wr(eeh_pkg::OFS_ADDR, {17'h0, ra});
    wr(eeh_pkg::OFS_LEN, {26'h0, len});
    if (op == eeh_pkg::OP_RAND) exp_ptr = ra;
    run(op, 4'h2);
    for (int i = 0; i <= len; i++) begin
      rd(eeh_pkg::OFS_BUF + 9'(4 * i), d);
      `CHK("read byte", {24'h0, shadow[exp_ptr]}, d)
      exp_ptr = exp_ptr + 1'b1;
    end
  endtask : do_read

  initial begin
    void'($urandom(4352));
    dev_strap = 2'($urandom);
    for (int i = 0; i < 32768; i++) shadow[i] = i[7:0] ^ {1'b0, i[14:8]};
    repeat (16) @(posedge clock_i);
    srst_i <= 1'b0;
    rd(eeh_pkg::OFS_STAT, d);
    `CHK("status after reset", 32'h0, d)
    rd(9'h014, d);
    `CHK("unmapped read", 32'h0, d)
    `CHK("idle clock", 1'b1, scl_o)
    `CHK("data drive level", 1'b0, sda_o)
    // Page-end write wraps to the page start
    do_write(15'h1f3e, 6'd3, 1'b0);
    do_read(eeh_pkg::OP_RAND, 15'h1f3e, 6'd1);
    do_read(eeh_pkg::OP_CUR, 15'h0, 6'd1);
    do_read(eeh_pkg::OP_RAND, 15'h1f00, 6'd1);
    for (int k = 0; k < 3; k++) begin
      a = 15'($urandom);
      n = 6'($urandom_range(7));
      do_write(a, n, 1'b0);
      do_read(eeh_pkg::OP_RAND, a, n);
    end
    do_write(15'h2a05, 6'd63, 1'b0);
    do_read(eeh_pkg::OP_RAND, 15'h2a00, 6'd7);
    do_write(15'h0123, 6'd2, 1'b1);
    do_read(eeh_pkg::OP_RAND, 15'h0123, 6'd2);
    do_read(eeh_pkg::OP_RAND, 15'h7ffe, 6'd3);
    wr(eeh_pkg::OFS_CFG, {30'h0, ~dev_strap});
    run(eeh_pkg::OP_CUR, 4'h6);
    wr(eeh_pkg::OFS_CFG, {30'h0, dev_strap});
    run(eeh_pkg::OP_RECOV, 4'h2);
    stuck <= 1'b1;
    run(eeh_pkg::OP_RECOV, 4'h6);
    stuck <= 1'b0;
    do_read(eeh_pkg::OP_RAND, 15'h1f3e, 6'd0);
    print_verdict();
  end
endmodule : tb_eeh_host
